// file: rtl/sli_consts.svh
// Purpose: constants for the strap latch and indicator block
// Assumes: 100 MHz clk, straps steady while nrst is low
// Notes: constant macros follow
`ifndef SLI_CONSTS_SVH
`define SLI_CONSTS_SVH
`define SLI_CLK_MHZ 100
`define SLI_BLINK_NS 100000000
`define SLI_BLINK_CYC (`SLI_BLINK_NS / 1000 * `SLI_CLK_MHZ / 1000)
`define SLI_CTL_SPEED_BIT 13
`define SLI_BCAST_BIT 9
`define SLI_MODE_HI 5
`define SLI_MODE_LO 4
`define SLI_MODE_SPEED 2'h0
`define SLI_MODE_ACT 2'h1
`define SLI_ADDR_RST 3'h1
`define SLI_ADDR_UPPER 2'h0
`define SLI_IF_NORMAL 3'h0
`define SLI_IF_B2B 3'h6
`define SLI_BCAST_ADDR 5'h00
`endif

// file: rtl/sli_pkg.sv
package sli_pkg;
  typedef enum logic [2:0] {
    SLI_IF_MII = 3'h1,
    SLI_IF_BACK = 3'h2,
    SLI_IF_RSVD = 3'h4
  } sli_if_mode_t;
  typedef enum logic [1:0] {
    SLI_PH_CONFIG = 2'h1,
    SLI_PH_RUN = 2'h2
  } sli_phase_t;
endpackage

// file: rtl/sli_blinker.sv
// Purpose: free-running blink counter and phase
// Assumes: single 100 MHz clock
// Notes: phase flips once per blink period
`timescale 1ns/1ps
`include "sli_consts.svh"
module sli_blinker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // blink phase
  output logic phase
);
  localparam int unsigned CYC = `SLI_BLINK_CYC;
  logic [31:0] count;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0;
      phase <= 1'b0;
    end else if (count == CYC - 1) begin
      count <= 32'h0;
      phase <= ~phase;
    end else begin
      count <= count + 32'h1;
    end
  end
endmodule

// file: rtl/sli_top.sv
// Purpose: reset-time strap capture and indicator pin drive
// Assumes: strap pins steady during reset, pins driven only after release
// Notes: control bits are plain ports, no register bus
`timescale 1ns/1ps
`include "sli_consts.svh"
module sli_top (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // indicator one pin, doubles as speed strap
  input wire logic indicator_one_pin_in,
  output logic indicator_one_pin_out,
  output logic indicator_one_pin_oe,
  // indicator zero pin
  output logic indicator_zero_pin_out,
  output logic indicator_zero_pin_oe,
  // other straps
  input wire logic [2:0] station_address_straps,
  input wire logic broadcast_disable_strap,
  input wire logic [2:0] config_straps,
  // software control
  input wire logic [15:0] ctl_reg_1f,
  input wire logic [15:0] ctl_reg_16,
  input wire logic ctl_speed_wr,
  input wire logic ctl_speed_wdata,
  // line status
  input wire logic link_up,
  input wire logic activity,
  input wire logic speed_100,
  // management address check
  input wire logic [4:0] mgmt_addr,
  output logic addr_match,
  // captured configuration
  output logic speed_select,
  output logic [4:0] station_address,
  output logic bcast_strap,
  output logic bcast_unique,
  output logic [2:0] if_mode_code,
  output sli_pkg::sli_if_mode_t if_mode,
  output sli_pkg::sli_phase_t phase
);
  logic armed;
  logic blink;
  logic [1:0] led_mode;

  function automatic sli_pkg::sli_if_mode_t decode_if(input logic [2:0] c);
    if (c == `SLI_IF_NORMAL) begin
      decode_if = sli_pkg::SLI_IF_MII;
    end else if (c == `SLI_IF_B2B) begin
      decode_if = sli_pkg::SLI_IF_BACK;
    end else begin
      decode_if = sli_pkg::SLI_IF_RSVD;
    end
  endfunction

  function automatic logic one_level(
    input logic [1:0] m,
    input logic fast,
    input logic busy,
    input logic ph
  );
    unique case (m)
      `SLI_MODE_SPEED: begin
        one_level = ~fast;
      end
      `SLI_MODE_ACT: begin
        one_level = busy ? ph : 1'b1;
      end
      default: begin
        // reserved modes keep the lamp dark
        one_level = 1'b1;
      end
    endcase
  endfunction

  function automatic logic zero_level(
    input logic [1:0] m,
    input logic up,
    input logic busy,
    input logic ph
  );
    unique case (m)
      `SLI_MODE_SPEED: begin
        // link with activity blink
        zero_level = up ? (busy ? ph : 1'b0) : 1'b1;
      end
      default: begin
        zero_level = ~up;
      end
    endcase
  endfunction

  sli_blinker u_blink (
    .clk(clk),
    .nrst(nrst),
    .phase(blink)
  );

  // first clock after release is the sampling edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
      phase <= sli_pkg::SLI_PH_CONFIG;
    end else begin
      armed <= 1'b1;
      phase <= sli_pkg::SLI_PH_RUN;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_select <= 1'b1;
    end else if (!armed) begin
      speed_select <= indicator_one_pin_in;
    end else if (ctl_speed_wr) begin
      speed_select <= ctl_speed_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      station_address <= {`SLI_ADDR_UPPER, `SLI_ADDR_RST};
    end else if (!armed) begin
      station_address <= {`SLI_ADDR_UPPER, station_address_straps};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bcast_strap <= 1'b0;
    end else if (!armed) begin
      bcast_strap <= broadcast_disable_strap;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      if_mode_code <= `SLI_IF_NORMAL;
    end else if (!armed) begin
      if_mode_code <= config_straps;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      if_mode <= sli_pkg::SLI_IF_MII;
    end else if (!armed) begin
      if_mode <= decode_if(config_straps);
    end
  end

  assign bcast_unique = bcast_strap | ctl_reg_16[`SLI_BCAST_BIT];

  assign addr_match = (mgmt_addr == station_address) ||
    (!bcast_unique && mgmt_addr == `SLI_BCAST_ADDR);

  assign led_mode = ctl_reg_1f[`SLI_MODE_HI:`SLI_MODE_LO];

  // pins stay released while straps are read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indicator_one_pin_oe <= 1'b0;
      indicator_zero_pin_oe <= 1'b0;
    end else begin
      indicator_one_pin_oe <= armed;
      indicator_zero_pin_oe <= armed;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indicator_one_pin_out <= 1'b1;
    end else begin
      indicator_one_pin_out <= one_level(led_mode, speed_100, activity,
        blink);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indicator_zero_pin_out <= 1'b1;
    end else begin
      indicator_zero_pin_out <= zero_level(led_mode, link_up, activity,
        blink);
    end
  end
endmodule

// file: tb/sli_board.sv
// Purpose: board strap and lamp side
// Assumes: pull sets the pin when idle
// Notes: bench picks strap level
`timescale 1ns/1ps
module sli_board (
  // pin and strap
  input wire logic oe, out, strap,
  output logic pin
);
  assign pin = oe ? out : strap;
endmodule

// file: tb/sli_chk_assertions.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound by port names
`timescale 1ns/1ps
module sli_chk (
  // observed ports
  input wire logic clk, nrst, indicator_one_pin_in, indicator_one_pin_oe,
  indicator_one_pin_out, indicator_zero_pin_out, link_up, activity,
  speed_100, addr_match, speed_select, bcast_strap, bcast_unique,
  input wire logic [15:0] ctl_reg_1f, ctl_reg_16,
  input wire logic [4:0] mgmt_addr, station_address,
  input wire logic [2:0] station_address_straps, if_mode_code,
  input sli_pkg::sli_if_mode_t if_mode,
  input sli_pkg::sli_phase_t phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire run = phase == sli_pkg::SLI_PH_RUN;
  wire on = indicator_one_pin_oe;
  wire [1:0] md = ctl_reg_1f[5:4];
  a_upper_zero: assert property (
    station_address[4:3] == 2'h0) else $error("upper");
  a_bcast_zero: assert property (
    mgmt_addr == 5'h00 && !bcast_unique |-> addr_match) else $error("bcast");
  a_unique_src: assert property (
    bcast_unique == (bcast_strap | ctl_reg_16[9])) else $error("unique");
  a_strap_take: assert property (
    run && !$past(run) |-> speed_select == $past(indicator_one_pin_in) &&
    station_address[2:0] == $past(station_address_straps)) else $error("take");
  a_if_decode: assert property (run |-> if_mode == (
    if_mode_code == 3'h0 ? 3'h1 : if_mode_code == 3'h6 ? 3'h2 : 3'h4))
    else $error("decode");
  a_speed_lamp: assert property (on && $past(md) == 2'h0 |->
    indicator_one_pin_out == !$past(speed_100)) else $error("speed");
  a_idle_high: assert property (on && $past(md) == 2'h1 &&
    !$past(activity) |-> indicator_one_pin_out) else $error("idle");
  a_link_lamp: assert property (on && $past(md) == 2'h1 |->
    indicator_zero_pin_out == !$past(link_up)) else $error("link");
  c_bcast: cover property (mgmt_addr == 5'h00 && addr_match);
  c_back: cover property (run && if_mode == sli_pkg::SLI_IF_BACK);
  c_busy: cover property (on && md == 2'h1 && activity);
endmodule
bind sli_top sli_chk chk (.*);

// file: tb/testbench.sv
// Purpose: self-checking bench
// Assumes: 100 MHz clock
// Notes: strap loop, then lamps
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0, nrst = 1'h0, spd = 1'h1, activity = 1'h0;
  logic link_up = 1'h0, speed_100 = 1'h0, ctl_speed_wr = 1'h0;
  logic ctl_speed_wdata = 1'h0, broadcast_disable_strap = 1'h0;
  logic indicator_one_pin_in, indicator_one_pin_out, indicator_one_pin_oe;
  logic indicator_zero_pin_out, indicator_zero_pin_oe, addr_match;
  logic speed_select, bcast_strap, bcast_unique;
  logic [2:0] station_address_straps = 3'h1, config_straps = 3'h0;
  logic [2:0] if_mode_code;
  logic [15:0] ctl_reg_1f = 16'h0000, ctl_reg_16 = 16'h0000;
  logic [4:0] mgmt_addr = 5'h00, station_address;
  sli_pkg::sli_if_mode_t if_mode;
  sli_pkg::sli_phase_t phase;
  int errors = 0, checked = 0;
  sli_board board (.oe(indicator_one_pin_oe), .out(indicator_one_pin_out),
    .strap(spd), .pin(indicator_one_pin_in));
  sli_top dut (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [4:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_strap;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      nrst = 1'h0;
      station_address_straps = i[2:0];
      {config_straps, broadcast_disable_strap, spd} = {i[2:0], i[1:0]};
      repeat (4) @(negedge clk);
      nrst = 1'h1;
      @(negedge clk);
      chk("oe_cfg", indicator_one_pin_oe, 1'h0);
      repeat (2) @(negedge clk);
      chk("oe_run", indicator_one_pin_oe, 1'h1);
      chk("oe0_run", indicator_zero_pin_oe, 1'h1);
      chk("addr", station_address, {2'h0, i[2:0]});
      chk("speed", speed_select, i[0]);
      chk("mode", if_mode, i == 0 ? 5'h01 : i == 6 ? 5'h02 : 5'h04);
      chk("code", if_mode_code, i[2:0]);
      chk("bstrap", bcast_strap, i[1]);
      chk("hit0", addr_match, i == 0 || !i[1]);
      ctl_reg_16 = 16'h0200;
      #1 chk("uniq", bcast_unique, 1'h1);
      ctl_reg_16 = 16'h0000;
    end
    $display("t_strap done");
  endtask
  task automatic t_pins;
    {link_up, speed_100} = 2'h3;
    @(negedge clk);
    chk("spd00", indicator_one_pin_out, 1'h0);
    speed_100 = 1'h0;
    @(negedge clk);
    chk("spd10", indicator_one_pin_out, 1'h1);
    ctl_reg_1f = 16'h0010;
    @(negedge clk);
    chk("idle01", indicator_one_pin_out, 1'h1);
    chk("link01", indicator_zero_pin_out, 1'h0);
    {link_up, activity} = 2'h1;
    @(negedge clk);
    chk("down01", indicator_zero_pin_out, 1'h1);
    chk("busy01", indicator_one_pin_out, 1'h0);
    {ctl_speed_wr, ctl_speed_wdata} = 2'h2;
    @(negedge clk);
    ctl_speed_wr = 1'h0;
    chk("spdwr", speed_select, 1'h0);
    $display("t_pins done");
  endtask
  initial begin
    t_strap();
    t_pins();
    end_of_test();
  end
endmodule
